// ---- inc/psa_pkg.sv ----
// Package for the packed unsigned SIMD ALU: operations, layouts, carriers
// Summary of operation
// - Exchange add-sub: top = (a.hi + b.lo) >> 1
// - Exchange add-sub: bottom = (a.lo - b.hi) >> 1
// - Exchange sub-add: top = (a.hi - b.lo) >> 1
// - Exchange sub-add: bottom = (a.lo + b.hi) >> 1
// - Exchange operations never write condition flags
// - Halfword halving subtract, each lane halved
// - Byte halving subtract, each lane halved
// - Byte select steered by greater-equal flag bits
// - Other operations here never write flags
// - Sum of four byte absolute differences
// - Accumulating variant adds accumulator input
// - Halfword unsigned subtract, per lane
// - Byte unsigned subtract, per lane
// - Missing destination writes first operand register
package psa_pkg;

    localparam int unsigned PSA_DATA_W  = 32;
    localparam int unsigned PSA_HALF_W  = 16;
    localparam int unsigned PSA_BYTE_W  = 8;
    localparam int unsigned PSA_LANES_B = 4;
    localparam int unsigned PSA_LANES_H = 2;
    localparam int unsigned PSA_IDX_W   = 4;
    localparam int unsigned PSA_SAD_W   = 10;

    // Register indices that the stream must not name
    localparam logic [PSA_IDX_W-1:0] PSA_IDX_STACK_PTR = 4'hd;
    localparam logic [PSA_IDX_W-1:0] PSA_IDX_PROG_CNT  = 4'hf;

    localparam logic [PSA_DATA_W-1:0] PSA_RESULT_RST = 32'h0000_0000;

    typedef enum logic [3:0] {
        PSA_OP_HALVING_ADD_SUB_EXCHANGE    = 4'h0,
        PSA_OP_HALVING_SUB_ADD_EXCHANGE    = 4'h1,
        PSA_OP_HALFWORD_HALVING_SUBTRACT   = 4'h2,
        PSA_OP_BYTE_HALVING_SUBTRACT       = 4'h3,
        PSA_OP_BYTE_SELECT                 = 4'h4,
        PSA_OP_BYTE_ABS_DIFF_SUM           = 4'h5,
        PSA_OP_BYTE_ABS_DIFF_SUM_ACC       = 4'h6,
        PSA_OP_HALFWORD_UNSIGNED_SUBTRACT  = 4'h7,
        PSA_OP_BYTE_UNSIGNED_SUBTRACT      = 4'h8
    } psa_op_t;

    // One issued instruction from the decode stage
    typedef struct packed {
        logic                    valid;
        psa_op_t                 op;
        logic                    cond_pass;
        logic                    dst_given;
        logic [PSA_IDX_W-1:0]    dst_idx;
        logic [PSA_IDX_W-1:0]    first_idx;
        logic [PSA_IDX_W-1:0]    second_idx;
        logic [PSA_IDX_W-1:0]    acc_idx;
        logic [PSA_LANES_B-1:0]  greater_equal_flags;
        logic [PSA_DATA_W-1:0]   first_operand_reg;
        logic [PSA_DATA_W-1:0]   second_operand_reg;
        logic [PSA_DATA_W-1:0]   accumulator_input;
    } psa_req_t;

    // Register file write-back
    typedef struct packed {
        logic                    wr_en;
        logic [PSA_IDX_W-1:0]    wr_idx;
        logic [PSA_DATA_W-1:0]   wr_data;
    } psa_wb_t;

endpackage : psa_pkg

// ---- rtl/psa_alu.sv ----
// Packed unsigned SIMD ALU: one-cycle registered datapath and write-back
`timescale 1ns/1ps
module psa_alu
    import psa_pkg::*;
(
    input  wire logic     i_clk,
    input  wire logic     i_rst,
    input  wire psa_req_t i_req,
    output psa_wb_t       o_wb,
    output logic          o_flags_wr,
    output logic          o_restrict_err
);

    // Halving lane: extra top bit keeps the carry or borrow after the shift
    function automatic logic [PSA_HALF_W-1:0] half_add(
        input logic [PSA_HALF_W-1:0] a,
        input logic [PSA_HALF_W-1:0] b
    );
        logic [PSA_HALF_W:0] s;
        s = {1'b0, a} + {1'b0, b};
        return s[PSA_HALF_W:1];
    endfunction : half_add

    // Halving difference: the borrow lands in the top result bit
    function automatic logic [PSA_HALF_W-1:0] half_sub(
        input logic [PSA_HALF_W-1:0] a,
        input logic [PSA_HALF_W-1:0] b
    );
        logic [PSA_HALF_W:0] s;
        s = {1'b0, a} - {1'b0, b};
        return s[PSA_HALF_W:1];
    endfunction : half_sub

    // Byte form of the halving difference
    function automatic logic [PSA_BYTE_W-1:0] byte_half_sub(
        input logic [PSA_BYTE_W-1:0] a,
        input logic [PSA_BYTE_W-1:0] b
    );
        logic [PSA_BYTE_W:0] s;
        s = {1'b0, a} - {1'b0, b};
        return s[PSA_BYTE_W:1];
    endfunction : byte_half_sub

    // Absolute difference never wraps, so eight bits suffice
    function automatic logic [PSA_BYTE_W-1:0] byte_abs_diff(
        input logic [PSA_BYTE_W-1:0] a,
        input logic [PSA_BYTE_W-1:0] b
    );
        logic [PSA_BYTE_W-1:0] d;
        d = (a >= b) ? (a - b) : (b - a);
        return d;
    endfunction : byte_abs_diff

    // Operand aliases and their halfword views
    logic [PSA_DATA_W-1:0] a;
    logic [PSA_DATA_W-1:0] b;
    logic [PSA_HALF_W-1:0] a_hi;
    logic [PSA_HALF_W-1:0] a_lo;
    logic [PSA_HALF_W-1:0] b_hi;
    logic [PSA_HALF_W-1:0] b_lo;

    assign a    = i_req.first_operand_reg;
    assign b    = i_req.second_operand_reg;
    assign a_hi = a[PSA_DATA_W-1:PSA_HALF_W];
    assign a_lo = a[PSA_HALF_W-1:0];
    assign b_hi = b[PSA_DATA_W-1:PSA_HALF_W];
    assign b_lo = b[PSA_HALF_W-1:0];

    // Per-lane results, all computed in parallel and picked by the op
    logic [PSA_DATA_W-1:0] hasx_res;
    logic [PSA_DATA_W-1:0] hsax_res;
    logic [PSA_DATA_W-1:0] hhsub_res;
    logic [PSA_DATA_W-1:0] bhsub_res;
    logic [PSA_DATA_W-1:0] sel_res;
    logic [PSA_DATA_W-1:0] husub_res;
    logic [PSA_DATA_W-1:0] busub_res;
    logic [PSA_SAD_W-1:0]  sad_sum;
    logic [PSA_DATA_W-1:0] sad_res;
    logic [PSA_DATA_W-1:0] sada_res;

    // Exchange forms pair opposite halves of the two operands
    logic [PSA_HALF_W-1:0] asx_top;
    logic [PSA_HALF_W-1:0] asx_bot;
    logic [PSA_HALF_W-1:0] sax_top;
    logic [PSA_HALF_W-1:0] sax_bot;
    assign asx_top  = half_add(a_hi, b_lo);
    assign asx_bot  = half_sub(a_lo, b_hi);
    assign sax_top  = half_sub(a_hi, b_lo);
    assign sax_bot  = half_add(a_lo, b_hi);
    assign hasx_res = {asx_top, asx_bot};
    assign hsax_res = {sax_top, sax_bot};

    // Halfword lanes
    genvar gh;
    generate
        for (gh = 0; gh < PSA_LANES_H; gh++) begin : g_half
            assign hhsub_res[gh*PSA_HALF_W +: PSA_HALF_W] =
                half_sub(a[gh*PSA_HALF_W +: PSA_HALF_W],
                         b[gh*PSA_HALF_W +: PSA_HALF_W]);
            assign husub_res[gh*PSA_HALF_W +: PSA_HALF_W] =
                a[gh*PSA_HALF_W +: PSA_HALF_W]
                - b[gh*PSA_HALF_W +: PSA_HALF_W];
        end
    endgenerate

    // Byte lanes of the two subtract forms
    genvar gb;
    generate
        for (gb = 0; gb < PSA_LANES_B; gb++) begin : g_byte
            assign bhsub_res[gb*PSA_BYTE_W +: PSA_BYTE_W] =
                byte_half_sub(a[gb*PSA_BYTE_W +: PSA_BYTE_W],
                              b[gb*PSA_BYTE_W +: PSA_BYTE_W]);
            assign busub_res[gb*PSA_BYTE_W +: PSA_BYTE_W] =
                a[gb*PSA_BYTE_W +: PSA_BYTE_W]
                - b[gb*PSA_BYTE_W +: PSA_BYTE_W];
        end
    endgenerate

    // Select lanes; a set flag bit takes the first operand's byte
    generate
        for (gb = 0; gb < PSA_LANES_B; gb++) begin : g_sel
            assign sel_res[gb*PSA_BYTE_W +: PSA_BYTE_W] =
                i_req.greater_equal_flags[gb]
                ? a[gb*PSA_BYTE_W +: PSA_BYTE_W]
                : b[gb*PSA_BYTE_W +: PSA_BYTE_W];
        end
    endgenerate

    // Per-lane absolute differences feed the adder tree
    logic [PSA_BYTE_W-1:0] abs_d [PSA_LANES_B];
    generate
        for (gb = 0; gb < PSA_LANES_B; gb++) begin : g_abs
            assign abs_d[gb] = byte_abs_diff(a[gb*PSA_BYTE_W +: PSA_BYTE_W],
                                             b[gb*PSA_BYTE_W +: PSA_BYTE_W]);
        end
    endgenerate

    // Two-level adder tree; ten bits hold the largest sum of four bytes
    logic [PSA_SAD_W-1:0]  sad_pair_lo;
    logic [PSA_SAD_W-1:0]  sad_pair_hi;
    assign sad_pair_lo = PSA_SAD_W'(abs_d[0]) + PSA_SAD_W'(abs_d[1]);
    assign sad_pair_hi = PSA_SAD_W'(abs_d[2]) + PSA_SAD_W'(abs_d[3]);
    assign sad_sum  = sad_pair_lo + sad_pair_hi;
    assign sad_res  = PSA_DATA_W'(sad_sum);
    // Accumulation wraps modulo two to the word width
    assign sada_res = i_req.accumulator_input + sad_res;

    // Operation mux
    logic [PSA_DATA_W-1:0] result;
    logic                  op_known;
    always_comb begin
        // Defaults keep the mux free of latches
        result   = PSA_RESULT_RST;
        op_known = 1'b1;
        unique case (i_req.op)
            PSA_OP_HALVING_ADD_SUB_EXCHANGE:   result = hasx_res;
            PSA_OP_HALVING_SUB_ADD_EXCHANGE:   result = hsax_res;
            PSA_OP_HALFWORD_HALVING_SUBTRACT:  result = hhsub_res;
            PSA_OP_BYTE_HALVING_SUBTRACT:      result = bhsub_res;
            PSA_OP_BYTE_SELECT:                result = sel_res;
            PSA_OP_BYTE_ABS_DIFF_SUM:          result = sad_res;
            PSA_OP_BYTE_ABS_DIFF_SUM_ACC:      result = sada_res;
            PSA_OP_HALFWORD_UNSIGNED_SUBTRACT: result = husub_res;
            PSA_OP_BYTE_UNSIGNED_SUBTRACT:     result = busub_res;
            // Undefined op codes never reach the register file
            default:                           op_known = 1'b0;
        endcase
    end

    // Restricted register use; select is exempt, accumulator only for acc
    function automatic logic is_restricted(input logic [PSA_IDX_W-1:0] x);
        return (x == PSA_IDX_STACK_PTR) || (x == PSA_IDX_PROG_CNT);
    endfunction : is_restricted

    // Omitted destination field falls back to the first operand register
    logic [PSA_IDX_W-1:0] dst_eff;
    logic                 restrict_hit;
    logic                 ops_restricted;
    logic                 acc_restricted;
    assign dst_eff = i_req.dst_given ? i_req.dst_idx
                                     : i_req.first_idx;

    // Accumulator index only counts for the accumulating form
    assign ops_restricted = is_restricted(dst_eff)
                            || is_restricted(i_req.first_idx)
                            || is_restricted(i_req.second_idx);
    assign acc_restricted = (i_req.op == PSA_OP_BYTE_ABS_DIFF_SUM_ACC)
                            && is_restricted(i_req.acc_idx);
    assign restrict_hit   = (i_req.op != PSA_OP_BYTE_SELECT)
                            && (ops_restricted || acc_restricted);

    // Write-back register; a failed condition or bad op leaves dest alone
    always_ff @(posedge i_clk or posedge i_rst) begin
        if (i_rst) begin
            o_wb.wr_en   <= 1'b0;
            o_wb.wr_idx  <= '0;
            o_wb.wr_data <= PSA_RESULT_RST;
        end else begin
            o_wb.wr_en   <= i_req.valid && i_req.cond_pass
                            && op_known;
            o_wb.wr_idx  <= dst_eff;
            o_wb.wr_data <= result;
        end
    end

    // Flags are never written by any operation of this unit
    always_ff @(posedge i_clk or posedge i_rst) begin
        if (i_rst) begin
            o_flags_wr <= 1'b0;
        end else begin
            o_flags_wr <= 1'b0;
        end
    end

    // Diagnostic only: the write still happens, as the result is defined
    always_ff @(posedge i_clk or posedge i_rst) begin
        if (i_rst) begin
            o_restrict_err <= 1'b0;
        end else begin
            o_restrict_err <= i_req.valid && restrict_hit;
        end
    end

endmodule : psa_alu

// ---- verif/psa_alu_assertions.sv ----
// Port checker for the packed unsigned SIMD ALU
`timescale 1ns/1ps
module psa_alu_checker
    import psa_pkg::*;
(
    input wire logic     i_clk,
    input wire logic     i_rst,
    input wire psa_req_t i_req,
    input wire psa_wb_t  o_wb,
    input wire logic     o_flags_wr,
    input wire logic     o_restrict_err
);
    psa_req_t   r_q;
    wire [31:0] a = r_q.first_operand_reg;
    wire [31:0] b = r_q.second_operand_reg;
    wire [31:0] d = o_wb.wr_data;
    wire        w = o_wb.wr_en;
    default clocking cb @(posedge i_clk); endclocking
    default disable iff (i_rst);
    // Last request kept, so each answer is judged against its own cause
    always_ff @(posedge i_clk or posedge i_rst) begin
        if (i_rst) r_q <= '0;
        else r_q <= i_req;
    end
    property p_take; i_req.valid && i_req.cond_pass && i_req.op <= 4'h8 |=> w;
    endproperty
    a_take: assert property (p_take) else $error("op not written");
    property p_skip; i_req.valid && !i_req.cond_pass |=> !w; endproperty
    a_skip: assert property (p_skip) else $error("failed op wrote");
    property p_dst;
        i_req.valid && !i_req.dst_given
            |=> o_wb.wr_idx == $past(i_req.first_idx);
    endproperty
    a_dst: assert property (p_dst) else $error("bad default dest");
    property p_flag; i_req.valid |=> !o_flags_wr [*2]; endproperty
    a_flag: assert property (p_flag) else $error("flags written");
    property p_asx;
        w && r_q.op == 4'h0 |-> d[31:16] == ({1'b0, a[31:16]} + b[15:0]) >> 1;
    endproperty
    a_asx: assert property (p_asx) else $error("exch top wrong");
    property p_hs;
        w && r_q.op == 4'h2 |-> d[31:16] == ({1'b0, a[31:16]} - b[31:16]) >> 1;
    endproperty
    a_hs: assert property (p_hs) else $error("halving sub wrong");
    property p_sel; w && r_q.op == 4'h4 |->
        d[31:24] == (r_q.greater_equal_flags[3] ? a[31:24] : b[31:24]);
    endproperty
    a_sel: assert property (p_sel) else $error("select wrong");
    property p_sub; w && r_q.op == 4'h8 |-> d[15:8] == a[15:8] - b[15:8];
    endproperty
    a_sub: assert property (p_sub) else $error("byte sub wrong");
    c_b2b: cover property (w ##1 w);
    c_err: cover property (o_restrict_err);
    c_skip: cover property (i_req.valid && !i_req.cond_pass);
endmodule : psa_alu_checker

bind psa_alu psa_alu_checker u_psa_alu_checker (.i_clk(i_clk), .i_rst(i_rst),
    .i_req(i_req), .o_wb(o_wb), .o_flags_wr(o_flags_wr),
    .o_restrict_err(o_restrict_err));

// ---- verif/psa_dec_model.sv ----
// Decode stage stand-in: presents the bench's request on falling edges
`timescale 1ns/1ps
module psa_dec_model
    import psa_pkg::*;
(
    input  wire logic     i_clk,
    input  wire psa_req_t i_cmd,
    output psa_req_t      o_req
);
    // Launch off the falling edge so the ALU samples a settled request
    initial begin
        o_req = '0;
        forever @(negedge i_clk) o_req <= i_cmd;
    end
endmodule : psa_dec_model

// ---- verif/psa_alu_tb_top.sv ----
// Self-checking bench for the packed unsigned SIMD ALU
`timescale 1ns/1ps
module psa_alu_tb_top
    import psa_pkg::*;
;
    logic       i_clk, i_rst, o_flags_wr, o_restrict_err;
    psa_req_t   cmd, i_req;
    psa_wb_t    o_wb;
    logic       cp = 1, dg = 1;
    logic [3:0] ge = '0, di = 4'h1, fi = 4'h2, si = 4'h3, ai = 4'h4;
    logic [31:0] c = '0;
    int         fails = 0, checks = 0;
    psa_dec_model u_psa_dec_model (.i_clk(i_clk), .i_cmd(cmd), .o_req(i_req));
    psa_alu u_psa_alu (.i_clk(i_clk), .i_rst(i_rst), .i_req(i_req),
        .o_wb(o_wb), .o_flags_wr(o_flags_wr), .o_restrict_err(o_restrict_err));
    initial begin
        i_clk = 1'b0;
        forever #12.5 i_clk = ~i_clk;
    end
    task automatic chk(string n, logic [31:0] e, logic [31:0] g);
        checks++;
        if (g !== e) begin
            fails++;
            $display("BAD %s exp %h got %h", n, e, g);
        end
    endtask : chk
    function automatic logic bad(logic [3:0] x);
        return x == 4'hd || x == 4'hf;
    endfunction : bad
    // One request, answered one cycle later; back to back when chained
    task automatic run(logic [3:0] op, logic [31:0] a, b, exp);
        logic en, er;
        en = cp && op <= 4'h8;
        er = op != 4'h4 && (bad(dg ? di : fi) || bad(fi) || bad(si)
                            || op == 4'h6 && bad(ai));
        cmd = {1'b1, op, cp, dg, di, fi, si, ai, ge, a, b, c};
        @(negedge i_clk);
        @(posedge i_clk);
        #1;
        chk("wr_en", en, o_wb.wr_en);
        if (en) begin
            chk("wr_idx", dg ? di : fi, o_wb.wr_idx);
            chk("wr_data", exp, o_wb.wr_data);
        end
        chk("restrict", er, o_restrict_err);
        chk("flags_wr", '0, o_flags_wr);
    endtask : run
    task automatic t_exch;
        run(4'h0,32'h00030001,32'h00020005,32'h0004ffff);
        run(4'h1,32'hffffffff,32'hffff0001,32'h7fffffff);
        $display("exchange test done");
    endtask : t_exch
    task automatic t_halve;
        run(4'h2,32'h00000010,32'h00010004,32'hffff0006);
        run(4'h3,32'h0010ff00,32'h000101ff,32'h00077f80);
        $display("halving test done");
    endtask : t_halve
    // Select is free of the index restriction, so dest 15 raises no error
    task automatic t_sel;
        ge = 4'h5;
        run(4'h4,32'h11223344,32'haabbccdd,32'haa22cc44);
        ge = 4'ha;
        di = 4'hf;
        run(4'h4,32'h11223344,32'haabbccdd,32'h11bb33dd);
        di = 4'h1;
        $display("select test done");
    endtask : t_sel
    task automatic t_sad;
        run(4'h5,32'h00ff1005,32'hff000510,32'h00000214);
        c = 32'hfffffff0;
        run(4'h6,32'h00ff1005,32'hff000510,32'h00000204);
        $display("abs diff test done");
    endtask : t_sad
    task automatic t_sub;
        run(4'h7,32'h00050003,32'h00060001,32'hffff0002);
        run(4'h8,32'h01020304,32'h02010505,32'hff01feff);
        $display("subtract test done");
    endtask : t_sub
    // Failed condition, undefined op, default dest, restricted index
    task automatic t_cond;
        cp = 1'b0;
        run(4'h0,32'h00030001,32'h00020005,32'h0);
        cp = 1'b1;
        run(4'h9,32'h00030001,32'h00020005,32'h0);
        dg = 1'b0;
        fi = 4'h7;
        run(4'h8,32'h00000000,32'h00000001,32'h000000ff);
        si = 4'hd;
        run(4'h7,32'h00000001,32'h00000002,32'h0000ffff);
        dg = 1'b1;
        fi = 4'h2;
        si = 4'h3;
        ai = 4'hf;
        run(4'h5,32'h00ff1005,32'hff000510,32'h00000214);
        run(4'h6,32'h00ff1005,32'hff000510,32'h00000204);
        ai = 4'h4;
        cmd.valid = 1'b0;
        @(negedge i_clk);
        @(posedge i_clk);
        #1;
        chk("idle wr_en", '0, o_wb.wr_en);
        $display("condition test done");
    endtask : t_cond
    task automatic close_out;
        $display("checks %0d fails %0d", checks, fails);
        if (fails == 0 && checks > 0)
            $display("ALL TESTS PASSED");
        else
            $display("TESTS FAILED");
        $finish;
    endtask : close_out
    initial begin
        cmd = '0;
        i_rst = 1'b1;
        repeat (12) @(posedge i_clk);
        @(negedge i_clk);
        i_rst = 1'b0;
        chk("reset wr_en", '0, o_wb.wr_en);
        t_exch();
        t_halve();
        t_sel();
        t_sad();
        t_sub();
        t_cond();
        close_out();
    end
    // Tests need under 40 cycles; a hang is cut well past that
    initial begin
        repeat (500) @(posedge i_clk);
        fails++;
        close_out();
    end
endmodule : psa_alu_tb_top
